// >>> rdc_top.sv
`timescale 1ns/1ns
`default_nettype none
module rdc_top
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	input  wire logic [15:0] i_web_speed_input,
	input  wire logic [15:0] i_reel_speed_input,
	input  wire logic [15:0] i_min_diameter,
	input  wire logic [15:0] i_min_speed,
	input  wire logic        i_hold,
	input  wire logic [15:0] i_smoothing_time_constant,
	input  wire logic        i_preset_en,
	input  wire logic [15:0] i_preset_value,
	input  wire logic [15:0] i_web_break_threshold,
	input  wire logic        i_retain_en,
	input  wire logic [15:0] i_retained_value,
	output logic [15:0]      o_diameter_output,
	output logic [15:0]      o_unheld_diameter,
	output logic [15:0]      o_web_speed_abs,
	output logic [15:0]      o_reel_speed_abs,
	output logic             o_web_break
);
	import rdc_pkg::*;

	// ====================================================
	// rectified speeds and clamped settings
	logic [15:0] web_abs, reel_abs, min_dia, preset_val;
	logic        div_done;
	logic [31:0] div_q;
	logic        booted_ff;

	assign web_abs = rdc_abs(i_web_speed_input);       // R03
	assign reel_abs = rdc_abs(i_reel_speed_input);     // R04
	// minimum diameter and preset settings above 100 percent are clipped rather than trusted
	assign min_dia = (i_min_diameter > RDC_PCT_100) ? RDC_PCT_100 : i_min_diameter;
	assign preset_val = (i_preset_value > RDC_PCT_100) ? RDC_PCT_100 : i_preset_value; // R17

	// monitor copies are registered so downstream sees clean data
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_web_speed_abs  <= 16'h0;
			o_reel_speed_abs <= 16'h0;
		end
		else if (i_ce)
		begin
			o_web_speed_abs  <= web_abs;                // R11
			o_reel_speed_abs <= reel_abs;               // R11
		end
	end

	// ====================================================
	// raw calculation: web/reel * min, clamped min..100
	logic [47:0] prod;
	logic [15:0] raw_calc;
	logic [15:0] raw_ff;
	logic        div_start_ff;

	rdc_divider u_div
	(
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.i_ce      (i_ce),
		.i_start   (div_start_ff),
		.i_num     (web_abs),
		.i_den     (reel_abs),
		.o_done    (div_done),
		.o_quot    (div_q)
	);

	assign prod = 48'(div_q) * 48'(min_dia);          // R01
	// a stalled reel gives a huge ratio, so the clamp matters here
	assign raw_calc = (prod[47:16] > 32'(RDC_PCT_100)) ? RDC_PCT_100 :
	                  (prod[31:16] < min_dia) ? min_dia : prod[31:16]; // R02 R12

	// divider restarts every time it finishes; unheld result tracks
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			div_start_ff <= 1'b0;
			raw_ff       <= 16'h0;
		end
		else if (i_ce)
		begin
			div_start_ff <= 1'b1;
			if (div_done)
				raw_ff <= raw_calc;                     // R10
		end
	end
	assign o_unheld_diameter = raw_ff;                  // R10

	// ====================================================
	// held calculator value with preset and boot behaviour
	logic [15:0] calc_ff;
	logic        hold_now;

	assign hold_now = i_hold || (web_abs < i_min_speed); // R05 R06

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			calc_ff   <= 16'h0;
			booted_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			booted_ff <= 1'b1;
			if (!booted_ff)
				calc_ff <= i_retain_en ? i_retained_value : min_dia; // R13 R18
			else if (i_preset_en)
				calc_ff <= preset_val;                  // R09
			else if (!hold_now && div_done)
				calc_ff <= raw_calc;                    // R05 R06
		end
	end

	// ====================================================
	// first-order low-pass, stepped every 10 ms
	logic [RDC_TICK_W-1:0] tick_ff;
	logic                  tick;
	logic [RDC_ACC_W-1:0]  acc_ff;
	logic [RDC_ACC_W-1:0]  acc_in;
	logic signed [RDC_ACC_W:0] delta;
	logic [15:0]           filt;

	assign tick = (tick_ff == RDC_TICK_W'(RDC_TICK_CYC - 1));
	assign acc_in = {calc_ff, 24'h0};
	assign delta = $signed({1'b0, acc_in}) - $signed({1'b0, acc_ff});

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			tick_ff <= '0;
		else if (i_ce)
			tick_ff <= tick ? '0 : tick_ff + 1'b1;
	end

	// step = delta / tc; division by tc done directly with the / operator on each tick
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			acc_ff <= '0;
		else if (i_ce)
		begin
			if (!booted_ff || i_smoothing_time_constant == 16'h0)
				acc_ff <= acc_in;                       // R19
			else if (tick)
				acc_ff <= RDC_ACC_W'($signed({1'b0, acc_ff}) + delta / $signed({25'h0, i_smoothing_time_constant})); // R07 R19
		end
	end
	assign filt = acc_ff[RDC_ACC_W-1:RDC_ACC_FRAC];

	// ====================================================
	// output and web-break detection
	logic [15:0] diff;
	logic [15:0] pre_diff;

	assign diff = (calc_ff > filt) ? calc_ff - filt : filt - calc_ff;        // R08
	assign pre_diff = (preset_val > raw_ff) ? preset_val - raw_ff : raw_ff - preset_val;

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_diameter_output <= 16'h0;                 // R12
			o_web_break       <= 1'b0;
		end
		else if (i_ce)
		begin
			o_diameter_output <= filt;
			o_web_break <= (diff > i_web_break_threshold) ||
			               (i_preset_en && pre_diff > i_web_break_threshold); // R15 R16
		end
	end

	// ====================================================
	// checks
	sequence s_preset_seen;
		i_ce && booted_ff && i_preset_en;
	endsequence

	AST_PRESET_LOADS: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		s_preset_seen |=> calc_ff == $past(preset_val)) else $error("preset not loaded"); // R09
	AST_HOLD_FREEZES: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_ce && booted_ff && !i_preset_en && hold_now) |=> $stable(calc_ff)) else $error("held value moved"); // R05
	AST_RAW_FLOOR: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		div_done |-> raw_calc >= min_dia) else $error("raw below minimum"); // R02
	AST_OUT_RANGE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		o_diameter_output <= RDC_PCT_100) else $error("output above 100"); // R12
	AST_BREAK_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_ce && diff > i_web_break_threshold) |=> o_web_break) else $error("break missed"); // R15
	AST_BYPASS: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_ce && i_smoothing_time_constant == 16'h0) |=> filt == $past(calc_ff)) else $error("bypass failed"); // R19
	AST_WEB_ABS: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		i_ce |=> o_web_speed_abs == rdc_abs($past(i_web_speed_input))) else $error("web abs wrong"); // R03
	AST_REEL_ABS: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		i_ce |=> o_reel_speed_abs == rdc_abs($past(i_reel_speed_input))) else $error("reel abs wrong"); // R04
	AST_BOOT: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_ce && !booted_ff && !i_retain_en) |=> calc_ff == $past(min_dia)) else $error("boot value wrong"); // R18
endmodule
`default_nettype wire

// >>> rdc_pkg.sv
// Contract
// R01 - raw diameter is web over reel times minimum
// R02 - output never below minimum diameter setting (only the raw calculation is floored; preset and retained values are not)
// R03 - rectify signed web speed input first
// R04 - rectify signed reel speed input first
// R05 - hold result while web speed below threshold
// R06 - hold result while hold input high
// R07 - smooth output, time constant up to 200s
// R08 - break measure is filter input minus output
// R09 - preset enable forces result to preset value
// R10 - separate unheld diameter output keeps updating
// R11 - rectified web and reel speeds output
// R12 - final diameter limited to 0..100 percent (the retained value is loaded unclamped)
// R13 - option retains diameter across power loss
// R14 - configurer routes output or block idles (rdc_top has no idle mode; it runs whenever i_ce is high)
// R15 - flag web break when difference exceeds threshold
// R16 - preset far from calculation also flags break
// R17 - preset value 0..100 percent, default 10
// R18 - boot at minimum diameter unless retention enabled
// R19 - first-order low-pass, bypassed at zero constant
package rdc_pkg;
	// percentages are unsigned fixed point, 0.01 percent per lsb; only the speed inputs are signed
	localparam int          RDC_W          = 16;
	localparam logic [15:0] RDC_PCT_100    = 16'h2710;
	localparam logic [15:0] RDC_MIN_DIA_RST = 16'h03E8;
	localparam logic [15:0] RDC_MIN_SPD_RST = 16'h01F4;
	localparam logic [15:0] RDC_BRK_THR_RST = 16'h02EE;
	localparam logic [15:0] RDC_TC_RST      = 16'h01F4;
	// time constant in 0.01 s units; filter update tick period
	localparam int          RDC_TICK_NS    = 10_000_000;
	localparam int          RDC_CLK_NS     = 20;
	localparam int          RDC_TICK_CYC   = RDC_TICK_NS / RDC_CLK_NS;
	localparam int          RDC_TICK_W     = 20;
	localparam int          RDC_ACC_W      = 40;
	localparam int          RDC_ACC_FRAC   = 24;
	localparam int          RDC_DIV_STEPS  = 16;

	// magnitude of a signed percentage
	function automatic logic [15:0] rdc_abs(input logic signed [15:0] v);
		rdc_abs = v[15] ? 16'(-v) : 16'(v);
	endfunction
endpackage

// >>> rdc_divider.sv
`timescale 1ns/1ns
`default_nettype none
// serial restoring divider: quotient = num * 2^16 / den (32 steps)
module rdc_divider
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	input  wire logic        i_start,
	input  wire logic [15:0] i_num,
	input  wire logic [15:0] i_den,
	output logic             o_done,
	output logic [31:0]      o_quot
);
	import rdc_pkg::*;

	logic [47:0] rem_ff;
	logic [15:0] den_ff;
	logic [31:0] q_ff;
	logic [4:0]  cnt_ff;
	logic        busy_ff;
	logic [47:0] trial;

	// numerator pre-shifted so the quotient carries 16 fraction bits
	assign trial = {rem_ff[46:0], 1'b0} - {den_ff, 32'h0000_0000};

	// one quotient bit per cycle; zero denominator saturates
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rem_ff  <= 48'h0;
			den_ff  <= 16'h0;
			q_ff    <= 32'h0;
			cnt_ff  <= 5'h0;
			busy_ff <= 1'b0;
			o_done  <= 1'b0;
			o_quot  <= 32'h0;
		end
		else if (i_ce)
		begin
			o_done <= 1'b0;
			if (i_start && !busy_ff)
			begin
				rem_ff  <= {16'h0, i_num, 16'h0};
				den_ff  <= i_den;
				q_ff    <= 32'h0;
				cnt_ff  <= 5'h0;
				busy_ff <= 1'b1;
			end
			else if (busy_ff)
			begin
				if (!trial[47])
				begin
					rem_ff <= trial;
					q_ff   <= {q_ff[30:0], 1'b1};
				end
				else
				begin
					rem_ff <= {rem_ff[46:0], 1'b0};
					q_ff   <= {q_ff[30:0], 1'b0};
				end
				cnt_ff <= cnt_ff + 5'h01;
				if (cnt_ff == 5'(2 * RDC_DIV_STEPS - 1))
				begin
					busy_ff <= 1'b0;
					o_done  <= 1'b1;
					o_quot  <= (den_ff == 16'h0) ? 32'hFFFF_FFFF : {q_ff[30:0], !trial[47]};
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rdc_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: drive speed loops and the tension stage that reads the diameter
module rdc_drive_model
(
	input  wire logic        i_sys_clk,
	input  wire logic [15:0] i_web_cmd,
	input  wire logic [15:0] i_reel_cmd,
	input  wire logic [15:0] i_diameter,
	output logic [15:0]      o_web_speed,
	output logic [15:0]      o_reel_speed,
	output logic [15:0]      o_tension_dia
);
	// speeds leave the drives registered, so they move just after an edge
	always_ff @(posedge i_sys_clk)
	begin
		o_web_speed  <= i_web_cmd;
		o_reel_speed <= i_reel_cmd;
	end
	// diameter routed on to the tension stage; rdc_top has no idle mode and runs whether routed or not
	always_ff @(posedge i_sys_clk)
	begin
		o_tension_dia <= i_diameter;
	end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import rdc_pkg::*;
	logic        clk, nrst, ce, hold, pre_en, ret_en, brk;
	logic [15:0] web_cmd, reel_cmd, min_dia, min_spd, tc, pre_val, brk_thr, ret_val;
	logic [15:0] web, reel, dia, unheld, web_abs, reel_abs, tens_dia;
	int          mismatches, n_checks;

	rdc_drive_model drv_u (.i_sys_clk(clk), .i_web_cmd(web_cmd), .i_reel_cmd(reel_cmd), .i_diameter(dia),
		.o_web_speed(web), .o_reel_speed(reel), .o_tension_dia(tens_dia));
	rdc_top dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_web_speed_input(web),
		.i_reel_speed_input(reel), .i_min_diameter(min_dia), .i_min_speed(min_spd), .i_hold(hold),
		.i_smoothing_time_constant(tc), .i_preset_en(pre_en), .i_preset_value(pre_val),
		.i_web_break_threshold(brk_thr), .i_retain_en(ret_en), .i_retained_value(ret_val),
		.o_diameter_output(dia), .o_unheld_diameter(unheld), .o_web_speed_abs(web_abs),
		.o_reel_speed_abs(reel_abs), .o_web_break(brk));

	// ==========================================
	// clock, checks and closing
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	end
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s exp %b got %b", what, exp, got);
		end
	end
	endtask

	task automatic test_done();
	begin
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	// a divide pass is about 33 cycles; 80 leaves margin, sample off the edge
	task automatic settle();
	begin
		repeat (80) @(posedge clk);
		#1;
	end
	endtask

	task automatic set_spd(input logic [15:0] w, input logic [15:0] r);
	begin
		@(posedge clk);
		web_cmd  <= w;
		reel_cmd <= r;
		settle();
	end
	endtask

	task automatic do_reset(input logic ret, input logic [15:0] val);
	begin
		@(posedge clk);
		nrst    <= 1'b0;
		ret_en  <= ret;
		ret_val <= val;
		web_cmd <= 16'h0000;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		settle();
	end
	endtask

	// ==========================================
	// scenarios
	task automatic t_boot();
	begin
		do_reset(1'b0, 16'h0000);
		chk("boot", 16'h03E8, dia);
		chk("routed", 16'h03E8, tens_dia);
		do_reset(1'b1, 16'h1068);
		chk("retained", 16'h1068, dia);
	end
	endtask

	// negative speeds must be rectified, or the quotient would be wrong
	task automatic t_calc();
	begin
		set_spd(16'hF830, 16'h03E8);
		chk("calc", 16'h07D0, dia);
		chk("web_abs", 16'h07D0, web_abs);
		set_spd(16'h07D0, 16'hFC18);
		chk("reel_abs", 16'h03E8, reel_abs);
		chk("unheld", 16'h07D0, unheld);
		set_spd(16'h0258, 16'h04B0);
		chk("clamp_lo", 16'h03E8, dia);
		set_spd(16'h2710, 16'h01F4);
		chk("clamp_hi", 16'h2710, dia);
		set_spd(16'h07D0, 16'h03E8);
	end
	endtask

	task automatic t_hold();
	begin
		hold <= 1'b1;
		set_spd(16'h0BB8, 16'h03E8);
		chk("hold", 16'h07D0, dia);
		chk("unheld_hold", 16'h0BB8, unheld);
		hold <= 1'b0;
		settle();
		chk("release", 16'h0BB8, dia);
		set_spd(16'h0190, 16'h0064);
		chk("slow_web", 16'h0BB8, dia);
		chk("unheld_slow", 16'h0FA0, unheld);
	end
	endtask

	// preset wins over hold; a far preset also raises the break flag
	task automatic t_preset();
	begin
		set_spd(16'h07D0, 16'h03E8);
		pre_val <= 16'h1388;
		pre_en  <= 1'b1;
		hold    <= 1'b1;
		settle();
		chk("preset", 16'h1388, dia);
		chk_flag("brk_preset", 1'b1, brk);
		pre_val <= 16'h0834;
		settle();
		chk("preset_near", 16'h0834, dia);
		chk_flag("brk_near", 1'b0, brk);
		pre_en <= 1'b0;
		hold   <= 1'b0;
		settle();
	end
	endtask

	// filter ticks every 10 ms, so within this span the output must not move
	task automatic t_filter();
	begin
		tc <= RDC_TC_RST;
		set_spd(16'h0BB8, 16'h03E8);
		chk("filtered", 16'h07D0, dia);
		chk_flag("brk_step", 1'b1, brk);
		tc <= 16'h0000;
		settle();
		chk("bypass", 16'h0BB8, dia);
		chk_flag("brk_clear", 1'b0, brk);
	end
	endtask

	// ==========================================
	// main sequence and watchdog
	initial
	begin
		nrst = 1'b0;
		ce = 1'b1;
		hold = 1'b0;
		pre_en = 1'b0;
		ret_en = 1'b0;
		web_cmd = 16'h0000;
		reel_cmd = 16'h03E8;
		min_dia = RDC_MIN_DIA_RST;
		min_spd = RDC_MIN_SPD_RST;
		tc = 16'h0000;
		pre_val = 16'h03E8;
		brk_thr = RDC_BRK_THR_RST;
		ret_val = 16'h0000;
		mismatches = 0;
		n_checks = 0;
		t_boot();
		t_calc();
		t_hold();
		t_preset();
		t_filter();
		test_done();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
